// [rtl/stc_snapshot_ctrl.sv]
// Snapshot trigger sequencer with Wishbone registers and interrupt
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - Config bits 7:6 give frames waited before readout without external shutter
// - Shutter bit set: exposure ends on sync event; clear: frame count used
// - Sync polarity bit set makes sync input active low, else active high
// - Level mode repeats sequences while trigger stays at its active level
// - Pulse mode runs one sequence per active trigger edge
// - Trigger polarity bit set selects rising edge, clear selects falling edge
// - Interrupt polarity bit set makes interrupt output active low
// - Interrupt output only asserts while interrupt enable bit is set
// - Trigger flag reads one after a trigger, cleared by reading
// - Readout-done flag reads one after readout ends, cleared by reading
// - CPU control: trigger only flags; CPU sets sequence enable to start
// - Automatic mode starts the sequence at once on a trigger
// - Internal sync bit reads one whenever a sync event is required
// - Busy bit reads one during snapshot pixel readout
// - Writing one to software trigger acts like a trigger pin event
// - Sequence enable lets a CPU controlled sequence proceed; resets to zero
module stc_snapshot_ctrl
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic snapshot_trig_i,
  input wire logic ext_sync_i,
  output logic irq_o,
  output logic readout_busy_o
);
  import stc_pkg::*;

  typedef struct packed {
    logic [7:0] cfg;
    logic int_en;
    logic cpu_ctl;
    logic seq_en;
    logic sw_trig;
    logic trig_flag;
    logic rd_flag;
    logic [1:0] mask;
    stc_seq_state_t state;
    logic [1:0] frames_left;
    logic [15:0] cnt;
    logic busy;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } stc_core_state_t;

  stc_core_state_t q_ff;
  stc_core_state_t nxt_q;

  logic trig_edge;
  logic trig_active;
  logic sync_active;
  logic bus_hit;
  logic bus_wr;
  logic start_req;
  logic sync_status;
  logic [7:0] mode_rd;

  stc_trig_detect u_detect (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .trig_pin_i(snapshot_trig_i),
    .sync_pin_i(ext_sync_i),
    .trig_edge_pol_i(q_ff.cfg[CFG_TRIG_POL]),
    .sync_pol_i(q_ff.cfg[CFG_SYNC_POL]),
    .trig_edge_o(trig_edge),
    .trig_active_o(trig_active),
    .sync_active_o(sync_active)
  );

  // Load the first phase of a sequence
  function automatic stc_core_state_t begin_seq(input stc_core_state_t s);
    stc_core_state_t r;
    r = s;
    if (s.cfg[CFG_SHUTTER])
    begin
      r.state = ST_EXPOSE;
    end
    else if (s.cfg[CFG_FRAMES_MSB:CFG_FRAMES_LSB] == 2'h0)
    begin
      r.state = ST_READOUT;
      r.cnt = READOUT_CYCLES - 16'h0001;
    end
    else
    begin
      r.state = ST_EXPOSE;
      r.frames_left = s.cfg[CFG_FRAMES_MSB:CFG_FRAMES_LSB];
      r.cnt = FRAME_CYCLES - 16'h0001;
    end
    begin_seq = r;
  endfunction

  assign bus_hit = wb_cyc_i & wb_stb_i & ~q_ff.ack;
  assign bus_wr = bus_hit & wb_we_i & wb_sel_i[0];

  // Pulse mode needs a fresh edge; level mode restarts while held active
  always_comb
  begin
    if (q_ff.cfg[CFG_LEVEL_MODE])
    begin
      start_req = trig_active | q_ff.sw_trig;
    end
    else
    begin
      start_req = trig_edge | q_ff.sw_trig;
    end
  end

  assign sync_status = sync_active | (q_ff.state == ST_EXPOSE && q_ff.cfg[CFG_SHUTTER]);

  always_comb
  begin
    mode_rd = 8'h00;
    mode_rd[MODE_INT_EN] = q_ff.int_en;
    mode_rd[MODE_TRIG_FLAG] = q_ff.trig_flag;
    mode_rd[MODE_RD_FLAG] = q_ff.rd_flag;
    mode_rd[MODE_CPU_CTL] = q_ff.cpu_ctl;
    mode_rd[MODE_SYNC] = sync_status;
    mode_rd[MODE_BUSY] = q_ff.busy;
    mode_rd[MODE_SEQ_EN] = q_ff.seq_en;
  end

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.sw_trig = 1'b0;
    nxt_q.ack = bus_hit;
    if (bus_hit)
    begin
      nxt_q.dat = 32'h0000_0000;
      if (wb_adr_i == reg_addr(IDX_CONFIG))
      begin
        nxt_q.dat[7:0] = q_ff.cfg;
        if (bus_wr)
        begin
          nxt_q.cfg = wb_dat_i[7:0] & CFG_WRITE_MASK;
        end
      end
      else if (wb_adr_i == reg_addr(IDX_MODE))
      begin
        nxt_q.dat[7:0] = mode_rd;
        if (bus_wr)
        begin
          nxt_q.int_en = wb_dat_i[MODE_INT_EN];
          nxt_q.cpu_ctl = wb_dat_i[MODE_CPU_CTL];
          nxt_q.seq_en = wb_dat_i[MODE_SEQ_EN];
          nxt_q.sw_trig = wb_dat_i[MODE_SW_TRIG];
        end
        else if (!wb_we_i)
        begin
          nxt_q.trig_flag = 1'b0;
          nxt_q.rd_flag = 1'b0;
        end
      end
      else if (wb_adr_i == reg_addr(IDX_IRQ_STATUS))
      begin
        nxt_q.dat[IRQ_TRIG] = q_ff.trig_flag;
        nxt_q.dat[IRQ_RD] = q_ff.rd_flag;
        if (bus_wr)
        begin
          if (wb_dat_i[IRQ_TRIG])
          begin
            nxt_q.trig_flag = 1'b0;
          end
          if (wb_dat_i[IRQ_RD])
          begin
            nxt_q.rd_flag = 1'b0;
          end
        end
      end
      else if (wb_adr_i == reg_addr(IDX_IRQ_MASK))
      begin
        nxt_q.dat[1:0] = q_ff.mask;
        if (bus_wr)
        begin
          nxt_q.mask = wb_dat_i[1:0];
        end
      end
    end

    // Sequencer; flag sets below win over clears above
    case (q_ff.state)
      ST_IDLE:
      begin
        if (start_req)
        begin
          nxt_q.trig_flag = 1'b1;
          if (!q_ff.cpu_ctl)
          begin
            nxt_q = begin_seq(nxt_q);
          end
          else if (nxt_q.seq_en)
          begin
            nxt_q.seq_en = 1'b0;
            nxt_q = begin_seq(nxt_q);
          end
          else
          begin
            nxt_q.state = ST_WAIT_EN;
          end
        end
      end
      ST_WAIT_EN:
      begin
        if (nxt_q.seq_en)
        begin
          nxt_q.seq_en = 1'b0;
          nxt_q = begin_seq(nxt_q);
        end
      end
      ST_EXPOSE:
      begin
        if (q_ff.cfg[CFG_SHUTTER])
        begin
          if (sync_active)
          begin
            nxt_q.state = ST_READOUT;
            nxt_q.cnt = READOUT_CYCLES - 16'h0001;
          end
        end
        else if (q_ff.cnt != 16'h0000)
        begin
          nxt_q.cnt = q_ff.cnt - 16'h0001;
        end
        else if (q_ff.frames_left <= 2'h1)
        begin
          nxt_q.state = ST_READOUT;
          nxt_q.cnt = READOUT_CYCLES - 16'h0001;
        end
        else
        begin
          nxt_q.frames_left = q_ff.frames_left - 2'h1;
          nxt_q.cnt = FRAME_CYCLES - 16'h0001;
        end
      end
      ST_READOUT:
      begin
        if (q_ff.cnt != 16'h0000)
        begin
          nxt_q.cnt = q_ff.cnt - 16'h0001;
        end
        else
        begin
          nxt_q.rd_flag = 1'b1;
          nxt_q.state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_q.state = ST_IDLE;
      end
    endcase

    nxt_q.busy = (nxt_q.state == ST_READOUT);
    // Interrupt level from enable, masked flags and polarity
    nxt_q.irq = nxt_q.cfg[CFG_IRQ_POL]
      ^ (nxt_q.int_en & |({nxt_q.rd_flag, nxt_q.trig_flag} & nxt_q.mask));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_ff <= '0;
      q_ff.cfg <= CFG_RESET;
      q_ff.mask <= MASK_RESET;
      q_ff.state <= ST_IDLE;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  assign wb_dat_o = q_ff.dat;
  assign wb_ack_o = q_ff.ack;
  assign irq_o = q_ff.irq;
  assign readout_busy_o = q_ff.busy;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow request");
  a_irq_level: assert property (irq_o == (q_ff.cfg[CFG_IRQ_POL]
    ^ (q_ff.int_en & |({q_ff.rd_flag, q_ff.trig_flag} & q_ff.mask))))
    else $error("interrupt level does not match flags");
  a_irq_disabled: assert property (!q_ff.int_en |-> irq_o == q_ff.cfg[CFG_IRQ_POL])
    else $error("interrupt active while disabled");
  a_trig_flag_set: assert property (q_ff.state == ST_IDLE && start_req |=> q_ff.trig_flag)
    else $error("trigger flag not set");
  a_read_clears: assert property (bus_hit && !wb_we_i
    && wb_adr_i == reg_addr(IDX_MODE)
    && q_ff.state == ST_EXPOSE |=> !q_ff.rd_flag && !q_ff.trig_flag)
    else $error("flags not cleared by read");
  a_cpu_waits: assert property (q_ff.state == ST_IDLE && start_req && q_ff.cpu_ctl
    && !q_ff.seq_en && !(bus_wr && wb_adr_i == reg_addr(IDX_MODE) && wb_dat_i[MODE_SEQ_EN])
    |=> q_ff.state == ST_WAIT_EN)
    else $error("CPU controlled sequence started without enable");
  a_wait_holds: assert property (q_ff.state == ST_WAIT_EN && !(bus_wr
    && wb_adr_i == reg_addr(IDX_MODE) && wb_dat_i[MODE_SEQ_EN]) |=> q_ff.state == ST_WAIT_EN)
    else $error("sequence left wait without enable");
  a_auto_starts: assert property (q_ff.state == ST_IDLE && start_req && !q_ff.cpu_ctl
    |=> q_ff.state == ST_EXPOSE || q_ff.state == ST_READOUT)
    else $error("automatic sequence did not start");
  a_pulse_once: assert property (!q_ff.cfg[CFG_LEVEL_MODE] && q_ff.state == ST_IDLE
    && !trig_edge && !q_ff.sw_trig |=> q_ff.state == ST_IDLE)
    else $error("sequence started without a trigger edge");
  a_level_restart: assert property (q_ff.cfg[CFG_LEVEL_MODE] && q_ff.state == ST_IDLE
    && trig_active |=> q_ff.state != ST_IDLE)
    else $error("level trigger did not restart sequence");
  a_busy_readout: assert property (readout_busy_o == (q_ff.state == ST_READOUT))
    else $error("busy does not match readout");
  a_readout_len: assert property ($rose(readout_busy_o) |-> ##31 readout_busy_o ##1 !readout_busy_o)
    else $error("readout busy length wrong");
  a_sw_trigger: assert property (bus_wr && wb_adr_i == reg_addr(IDX_MODE)
    && wb_dat_i[MODE_SW_TRIG] && !wb_dat_i[MODE_CPU_CTL] && q_ff.state == ST_IDLE
    |=> ##1 q_ff.state != ST_IDLE)
    else $error("software trigger ignored");
  a_shutter_wait: assert property (q_ff.state == ST_EXPOSE && q_ff.cfg[CFG_SHUTTER]
    && !sync_active |=> q_ff.state == ST_EXPOSE)
    else $error("shutter exposure ended without sync");
  a_readout_done: assert property ($fell(readout_busy_o) |-> q_ff.rd_flag)
    else $error("readout end did not set flag");

  c_cpu_wait: cover property (q_ff.state == ST_WAIT_EN ##1 q_ff.state == ST_EXPOSE);
  c_level_repeat: cover property (q_ff.cfg[CFG_LEVEL_MODE] && $fell(readout_busy_o)
    ##1 q_ff.state != ST_IDLE);
  c_shutter_read: cover property (q_ff.cfg[CFG_SHUTTER] && $rose(readout_busy_o));
  c_irq_raise: cover property (q_ff.int_en && $changed(irq_o));

endmodule

// [rtl/stc_pkg.sv]
// Package with register map, field positions, reset values and timing counts
package stc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONFIG = 8'h09;
  localparam logic [7:0] IDX_MODE = 8'h0a;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h11;

  // Configuration register fields
  localparam int unsigned CFG_FRAMES_LSB = 6;
  localparam int unsigned CFG_FRAMES_MSB = 7;
  localparam int unsigned CFG_SHUTTER = 5;
  localparam int unsigned CFG_SYNC_POL = 4;
  localparam int unsigned CFG_LEVEL_MODE = 2;
  localparam int unsigned CFG_TRIG_POL = 1;
  localparam int unsigned CFG_IRQ_POL = 0;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hf7;

  // Mode register fields
  localparam int unsigned MODE_INT_EN = 7;
  localparam int unsigned MODE_TRIG_FLAG = 6;
  localparam int unsigned MODE_RD_FLAG = 5;
  localparam int unsigned MODE_CPU_CTL = 4;
  localparam int unsigned MODE_SYNC = 3;
  localparam int unsigned MODE_BUSY = 2;
  localparam int unsigned MODE_SW_TRIG = 1;
  localparam int unsigned MODE_SEQ_EN = 0;

  // Interrupt status and mask fields
  localparam int unsigned IRQ_TRIG = 0;
  localparam int unsigned IRQ_RD = 1;

  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [1:0] MASK_RESET = 2'h3;

  // Sequence timing in clock cycles
  localparam logic [15:0] FRAME_CYCLES = 16'h0040;
  localparam logic [15:0] READOUT_CYCLES = 16'h0020;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT_EN = 4'b0010,
    ST_EXPOSE = 4'b0100,
    ST_READOUT = 4'b1000
  } stc_seq_state_t;

  function automatic logic [7:0] reg_addr(input logic [7:0] idx);
    reg_addr = {idx[5:0], 2'b00};
  endfunction

endpackage

// [rtl/stc_trig_detect.sv]
// Trigger pin edge and level detector with sync input polarity
`timescale 1ns/1ps
module stc_trig_detect
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic trig_pin_i,
  input wire logic sync_pin_i,
  input wire logic trig_edge_pol_i,
  input wire logic sync_pol_i,
  output logic trig_edge_o,
  output logic trig_active_o,
  output logic sync_active_o
);
  import stc_pkg::*;

  typedef struct packed {
    logic prev;
    logic edge_seen;
    logic active;
    logic sync;
  } stc_det_state_t;

  stc_det_state_t q_ff;
  stc_det_state_t nxt_q;

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.prev = trig_pin_i;
    // Active edge follows the edge polarity
    nxt_q.edge_seen = trig_edge_pol_i ? (trig_pin_i & ~q_ff.prev) : (~trig_pin_i & q_ff.prev);
    nxt_q.active = trig_pin_i ~^ trig_edge_pol_i;
    nxt_q.sync = sync_pin_i ^ sync_pol_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_ff <= '0;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  assign trig_edge_o = q_ff.edge_seen;
  assign trig_active_o = q_ff.active;
  assign sync_active_o = q_ff.sync;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_edge_polarity: assert property (trig_edge_o
    |-> ($past(trig_pin_i) == $past(trig_edge_pol_i))
    && ($past(trig_pin_i, 2) != $past(trig_edge_pol_i)))
    else $error("trigger edge of wrong polarity");
  a_sync_polarity: assert property (##1 sync_active_o == ($past(sync_pin_i) ^ $past(sync_pol_i)))
    else $error("sync active level wrong");

endmodule

// [tb/stc_ctl_model.sv]
// Camera controller model driving trigger and sync pins
`timescale 1ns/1ps
module stc_ctl_model
(
  input wire logic clk_i,
  output logic trig_o,
  output logic sync_o
);
  initial
  begin
    trig_o = 1'b1;
    sync_o = 1'b0;
  end
  // One active phase, then back to idle
  task automatic pulse(input logic act);
    trig_o <= act;
    repeat (4) @(posedge clk_i);
    trig_o <= ~act;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic set_trig(input logic v);
    trig_o <= v;
    @(posedge clk_i);
  endtask
  task automatic set_sync(input logic v);
    sync_o <= v;
    @(posedge clk_i);
  endtask
endmodule

// [tb/tb.sv]
// Testbench for the snapshot trigger sequencer
`timescale 1ns/1ps
module tb;
  import stc_pkg::*;
  localparam logic [7:0] A_CFG = {IDX_CONFIG[5:0], 2'b00};
  localparam logic [7:0] A_MODE = {IDX_MODE[5:0], 2'b00};
  localparam logic [7:0] A_STS = {IDX_IRQ_STATUS[5:0], 2'b00};
  localparam logic [7:0] A_MSK = {IDX_IRQ_MASK[5:0], 2'b00};
  logic clk_i;
  logic rst_i;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic irq;
  logic busy;
  logic trig;
  logic sync;
  logic [7:0] q;
  logic [3:0] sel_v = 4'hf;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int n [3];
  stc_snapshot_ctrl i_stc_snapshot_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .snapshot_trig_i(trig),
    .ext_sync_i(sync), .irq_o(irq), .readout_busy_o(busy));
  stc_ctl_model i_stc_ctl_model (.clk_i(clk_i), .trig_o(trig), .sync_o(sync));
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      finish_test();
    end
  end
  task automatic ok(input logic c);
    n_tests++;
    if (c !== 1'b1)
    begin
      err_count++;
      $display("[ERR] %0t mismatch, last read %h", $time, q);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= sel_v;
    wb_dat_w <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack !== 1'b1);
    q = wb_dat_r[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
    ok(k == 2);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    ok(q === e);
  endtask
  task automatic wbusy(input logic v, input int lim, output int c);
    c = 0;
    while (busy !== v && c < lim)
    begin
      @(posedge clk_i);
      c++;
    end
  endtask
  task automatic seq_end(output int t);
    int c;
    wbusy(1'b1, 400, t);
    ok(t < 400);
    wbusy(1'b0, 100, c);
    ok(c == READOUT_CYCLES);
  endtask
  task automatic say(input string s);
    $display("test %s done, mismatches so far %0d", s, err_count);
  endtask
  initial
  begin
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_dat_w = 32'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(A_CFG, CFG_RESET);
    rd(A_MODE, 8'h00);
    rd(A_MSK, {6'h0, MASK_RESET});
    rd(A_STS, 8'h00);
    ok(irq === 1'b0);
    wb(1'b1, A_CFG, 8'hf8);
    sel_v = 4'he;
    wb(1'b1, A_CFG, 8'h01);
    sel_v = 4'hf;
    rd(A_CFG, CFG_WRITE_MASK & 8'hf8);
    wb(1'b1, 8'h30, 8'hff);
    rd(8'h30, 8'h00);
    say("reset");
    for (int f = 1; f < 4; f++)
    begin
      wb(1'b1, A_CFG, {f[1:0], 6'h00});
      wb(1'b1, A_MODE, 8'h80);
      i_stc_ctl_model.pulse(1'b0);
      seq_end(n[f - 1]);
      ok(irq === 1'b1);
      rd(A_MODE, 8'he0);
      rd(A_MODE, 8'h80);
      ok(irq === 1'b0);
    end
    ok(n[1] - n[0] == FRAME_CYCLES);
    ok(n[2] - n[1] == FRAME_CYCLES);
    wbusy(1'b1, 200, n[0]);
    ok(n[0] == 200);
    say("frames");
    wb(1'b1, A_MODE, 8'h82);
    seq_end(n[0]);
    rd(A_STS, 8'h03);
    wb(1'b1, A_MSK, 8'h00);
    ok(irq === 1'b0);
    wb(1'b1, A_MSK, 8'h03);
    ok(irq === 1'b1);
    wb(1'b1, A_STS, 8'h01);
    rd(A_STS, 8'h02);
    wb(1'b1, A_STS, 8'h02);
    ok(irq === 1'b0);
    rd(A_MODE, 8'h80);
    say("interrupt");
    wb(1'b1, A_MODE, 8'h90);
    i_stc_ctl_model.pulse(1'b0);
    wbusy(1'b1, 200, n[0]);
    ok(n[0] == 200);
    rd(A_MODE, 8'hd0);
    wb(1'b1, A_MODE, 8'h91);
    seq_end(n[0]);
    rd(A_MODE, 8'hb0);
    say("cpu");
    wb(1'b1, A_MODE, 8'h00);
    wb(1'b1, A_CFG, 8'h43);
    ok(irq === 1'b1);
    i_stc_ctl_model.set_trig(1'b0);
    wbusy(1'b1, 40, n[0]);
    ok(n[0] == 40);
    i_stc_ctl_model.pulse(1'b1);
    seq_end(n[0]);
    ok(irq === 1'b1);
    wb(1'b1, A_MODE, 8'h80);
    ok(irq === 1'b0);
    rd(A_MODE, 8'he0);
    say("polarity");
    wb(1'b1, A_CFG, 8'h07);
    i_stc_ctl_model.set_trig(1'b1);
    seq_end(n[0]);
    wbusy(1'b1, 20, n[1]);
    ok(n[1] < 20);
    i_stc_ctl_model.set_trig(1'b0);
    wbusy(1'b0, 100, n[1]);
    wbusy(1'b1, 100, n[1]);
    ok(n[1] == 100);
    rd(A_MODE, 8'he0);
    say("level");
    i_stc_ctl_model.set_sync(1'b1);
    wb(1'b1, A_CFG, 8'h70);
    i_stc_ctl_model.set_trig(1'b1);
    rd(A_MODE, 8'h80);
    i_stc_ctl_model.set_sync(1'b0);
    rd(A_MODE, 8'h88);
    i_stc_ctl_model.set_sync(1'b1);
    i_stc_ctl_model.pulse(1'b0);
    wbusy(1'b1, 300, n[0]);
    ok(n[0] == 300);
    rd(A_MODE, 8'hc8);
    i_stc_ctl_model.set_sync(1'b0);
    seq_end(n[0]);
    say("shutter");
    finish_test();
  end
endmodule
